//--- design/ddr2_burst_pkg.sv
// constants, codes and states of the ddr2 column-access burst engine
// What the document requires of this block and of its controller
// RULE_01: burst length is four or eight; each column command moves exactly that many beats
// RULE_02: address bit 3 of a mode register set picks sequential or interleaved order
// RULE_03: sequential order wraps within each four-beat group; second group is other nibble
// RULE_04: interleaved order is start column xor beat number
// RULE_05: no burst stop; bursts cut only by same-direction command at four-beat boundary
// RULE_06: chip select and cas low, ras and we high decode a burst read
// RULE_07: first read beat comes additive plus cas latency clocks after the read
// RULE_08: read strobe driven low one clock before data; beat zero on rising strobe
// RULE_09: controller spaces read to write by at least four clocks
// RULE_10: column commands every other clock give seamless bursts to open banks
// RULE_11: only eight-beat reads, without auto-precharge, cut by a read two clocks later
// RULE_12: spacing after an interrupted burst still uses the programmed burst length
// RULE_13: chip select, cas, we low and ras high decode a write; latency is read minus one
// RULE_14: controller drives strobe preamble one clock before write latency, then data
// RULE_15: write beats beyond the programmed length are ignored
// RULE_16: controller spaces write to read by cas latency plus one plus turnaround
// RULE_17: only eight-beat writes, without auto-precharge, cut by a write two clocks later
// RULE_18: write to precharge after interrupt is write latency plus half length plus recovery
// RULE_19: one mask bit per eight data lines, timed like data, ignored on reads
// RULE_20: precharge decode; address bit 10 closes all banks, else the addressed bank
// RULE_21: precharge after a read no sooner than additive latency plus half burst length
// RULE_22: controller waits row precharge time before reactivating a precharged bank
// RULE_23: column commands are at least two clocks apart
// RULE_24: address bit 10 with a read or write selects auto-precharge
// RULE_25: per-bank open state; column commands to closed banks rejected; precharge closes
package ddr2_burst_pkg;
    // command codes as {ras_n, cas_n, we_n}
    localparam logic [2:0] OP_MRS = 3'h0;
    localparam logic [2:0] OP_PRE = 3'h2;
    localparam logic [2:0] OP_ACT = 3'h3;
    localparam logic [2:0] OP_WR = 3'h4;
    localparam logic [2:0] OP_RD = 3'h5;
    localparam logic [1:0] BA_MRS = 2'h0;
    localparam logic [1:0] BA_EMRS = 2'h1;
    // mode register fields
    localparam int BL_LSB = 0;
    localparam int BT_BIT = 3;
    localparam int CL_LSB = 4;
    localparam int AL_LSB = 3;
    localparam int AP_BIT = 10;
    localparam logic [2:0] BL4_CODE = 3'h2;
    localparam logic [2:0] BL8_CODE = 3'h3;
    localparam logic [2:0] CL_MIN = 3'h3;
    localparam logic [2:0] CL_MAX = 3'h5;
    localparam logic [2:0] AL_MAX = 3'h4;
    localparam logic [2:0] CL_RESET = 3'h3;
    localparam logic [2:0] AL_RESET = 3'h0;
    localparam logic [2:0] LAST_BL4 = 3'h3;
    localparam logic [2:0] LAST_BL8 = 3'h7;
    localparam int ADDR_W = 13;
    localparam int BANKS = 4;
    // scheduling depth in link clocks, above the largest latency of 9
    localparam int SLOTS = 16;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_WRITE = 3'b100
    } burst_state_e;
endpackage

//--- design/ddr2_burst_access_timing.sv
// column-access burst engine of a four-bank ddr2 device
`timescale 1ns/1ps
module ddr2_burst_access_timing #(
    parameter int DQ_W = 8,
    parameter int COL_W = 3
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic ck,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] ba,
    input wire logic [ddr2_burst_pkg::ADDR_W-1:0] addr,
    input wire logic [DQ_W-1:0] dq_in,
    output logic [DQ_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic dqs_in,
    output logic dqs_out,
    output logic dqs_oe,
    input wire logic [DQ_W/8-1:0] dm_in,
    output logic [ddr2_burst_pkg::BANKS-1:0] bank_open,
    output logic burst_len8,
    output logic interleaved,
    output logic [2:0] cas_lat,
    output logic [2:0] add_lat,
    output logic cmd_reject
);
    import ddr2_burst_pkg::*;

    localparam int DM_W = DQ_W / 8;
    localparam int IN_W = 6 + 2 + ADDR_W + DQ_W + DM_W;

    // refuse widths the lane and ordering logic cannot serve
    if (DQ_W % 8 != 0 || DQ_W < 8 || COL_W < 3 || COL_W > 10)
    begin : g_bad_params
        $error("unsupported data width or column width");
    end

    // beat position inside the burst group
    function automatic logic [2:0] burst_pos(input logic [2:0] start, input logic [2:0] beat,
                                             input logic il);
        if (il)
            burst_pos = start ^ beat; // see RULE_04
        else
            burst_pos = {start[2] ^ beat[2], start[1:0] + beat[1:0]}; // see RULE_03
    endfunction

    // array index from bank, start column and beat
    function automatic logic [COL_W+1:0] mem_index(input logic [1:0] bk,
                                                   input logic [COL_W-1:0] sc,
                                                   input logic [2:0] beat, input logic il);
        logic [COL_W-1:0] col;
        col = (sc & ~COL_W'(7)) | COL_W'(burst_pos(sc[2:0], beat, il));
        mem_index = {bk, col};
    endfunction

    logic [IN_W-1:0] in_s1;
    logic [IN_W-1:0] in_s2;
    logic ck_d;
    logic dqs_d;
    logic [DQ_W-1:0] mem [0:(BANKS << COL_W)-1];
    logic sv [0:SLOTS-1];
    logic sw [0:SLOTS-1];
    logic sa [0:SLOTS-1];
    logic [1:0] sb [0:SLOTS-1];
    logic [COL_W-1:0] sc [0:SLOTS-1];
    burst_state_e state;
    logic [2:0] beat;
    logic [1:0] cur_bank;
    logic [COL_W-1:0] cur_col;
    logic cur_ap;

    // two-flop synchronisers for every link pin
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            in_s1 <= '0;
            in_s2 <= '0;
            ck_d <= 1'b0;
            dqs_d <= 1'b0;
        end
        else if (clk_en)
        begin
            in_s1 <= {ck, dqs_in, cs_n, ras_n, cas_n, we_n, ba, addr, dq_in, dm_in};
            in_s2 <= in_s1;
            ck_d <= in_s2[IN_W-1];
            dqs_d <= in_s2[IN_W-2];
        end
    end

    logic ck_s, dqs_s, cs_s;
    logic [2:0] op;
    logic [1:0] ba_s;
    logic [ADDR_W-1:0] addr_s;
    logic [DQ_W-1:0] dq_s;
    logic [DM_W-1:0] dm_s;
    assign {ck_s, dqs_s, cs_s, op, ba_s, addr_s, dq_s, dm_s} = in_s2;

    // link clock and strobe edges seen in the system domain
    logic ck_rise, ck_edge, dqs_rise, dqs_edge;
    assign ck_rise = ck_s & ~ck_d;
    assign ck_edge = ck_s ^ ck_d;
    assign dqs_rise = dqs_s & ~dqs_d;
    assign dqs_edge = dqs_s ^ dqs_d;

    // command decode on link clock rising edges
    logic cmd, is_rd, is_wr, accept, is_pre;
    logic [3:0] rl, wl, lat;
    assign cmd = ck_rise & ~cs_s;
    assign is_rd = cmd & (op == OP_RD); // see RULE_06
    assign is_wr = cmd & (op == OP_WR); // see RULE_13
    assign is_pre = cmd & (op == OP_PRE);
    assign accept = (is_rd | is_wr) & bank_open[ba_s]; // see RULE_25
    assign rl = {1'b0, add_lat} + {1'b0, cas_lat}; // see RULE_07
    assign wl = rl - 4'h1; // see RULE_13
    assign lat = (is_wr ? wl : rl) - 4'h1; // slot counts from the next shift

    // reject pulse for column command to a closed bank
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            cmd_reject <= 1'b0;
        else if (clk_en)
            cmd_reject <= (is_rd | is_wr) & ~bank_open[ba_s]; // see RULE_25
    end

    // mode and extended mode registers
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            burst_len8 <= 1'b0;
            interleaved <= 1'b0;
            cas_lat <= CL_RESET;
            add_lat <= AL_RESET;
        end
        else if (clk_en && cmd && op == OP_MRS)
        begin
            if (ba_s == BA_MRS)
            begin
                if (addr_s[BL_LSB+:3] == BL4_CODE || addr_s[BL_LSB+:3] == BL8_CODE)
                    burst_len8 <= addr_s[BL_LSB+:3] == BL8_CODE; // see RULE_01
                interleaved <= addr_s[BT_BIT]; // see RULE_02
                if (addr_s[CL_LSB+:3] >= CL_MIN && addr_s[CL_LSB+:3] <= CL_MAX)
                    cas_lat <= addr_s[CL_LSB+:3];
            end
            else if (ba_s == BA_EMRS && addr_s[AL_LSB+:3] <= AL_MAX)
                add_lat <= addr_s[AL_LSB+:3];
        end
    end

    // latency pipeline, one slot per link clock
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < SLOTS; i++)
            begin
                sv[i] <= 1'b0;
                sw[i] <= 1'b0;
                sa[i] <= 1'b0;
                sb[i] <= 2'h0;
                sc[i] <= '0;
            end
        end
        else if (clk_en && ck_rise)
        begin
            for (int i = 0; i < SLOTS - 1; i++)
            begin
                sv[i] <= sv[i+1];
                sw[i] <= sw[i+1];
                sa[i] <= sa[i+1];
                sb[i] <= sb[i+1];
                sc[i] <= sc[i+1];
            end
            sv[SLOTS-1] <= 1'b0;
            if (accept)
            begin
                sv[lat] <= 1'b1; // see RULE_07
                sw[lat] <= is_wr;
                sa[lat] <= addr_s[AP_BIT]; // see RULE_24
                sb[lat] <= ba_s;
                sc[lat] <= addr_s[COL_W-1:0];
            end
        end
    end

    // burst due this link clock; a new one cuts the running one
    logic due, due_rd, due_wr, pre_next, last_beat;
    logic [2:0] last;
    assign due = ck_rise & sv[0]; // see RULE_10
    assign due_rd = due & ~sw[0];
    assign due_wr = due & sw[0];
    assign pre_next = ck_rise & sv[1] & ~sw[1];
    assign last = burst_len8 ? LAST_BL8 : LAST_BL4; // see RULE_01 RULE_12
    assign last_beat = beat == last;

    // write capture on strobe edges, first on a rising edge
    logic wr_cap;
    logic [1:0] wb;
    logic [COL_W-1:0] wc;
    logic [2:0] wbeat;
    assign wr_cap = dqs_edge & (due_wr ? dqs_rise : (state == ST_WRITE &&
                    (beat != 3'h0 || dqs_rise))); // see RULE_15
    assign wb = due_wr ? sb[0] : cur_bank;
    assign wc = due_wr ? sc[0] : cur_col;
    assign wbeat = due_wr ? 3'h0 : beat;

    // burst state, beat counter and the burst's own fields
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE;
            beat <= 3'h0;
            cur_bank <= 2'h0;
            cur_col <= '0;
            cur_ap <= 1'b0;
        end
        else if (clk_en)
        begin
            if (due)
            begin
                state <= sw[0] ? ST_WRITE : ST_READ; // see RULE_05
                beat <= (sw[0] && wr_cap) ? 3'h1 : 3'h0;
                cur_bank <= sb[0];
                cur_col <= sc[0];
                cur_ap <= sa[0];
            end
            else
            begin
                case (state)
                    ST_READ:
                    begin
                        if (ck_edge)
                        begin
                            if (last_beat)
                                state <= ST_IDLE;
                            else
                                beat <= beat + 3'h1;
                        end
                    end
                    ST_WRITE:
                    begin
                        if (wr_cap)
                        begin
                            if (last_beat)
                                state <= ST_IDLE; // see RULE_15
                            else
                                beat <= beat + 3'h1;
                        end
                    end
                    ST_IDLE:
                        beat <= 3'h0;
                    default:
                        state <= ST_IDLE;
                endcase
            end
        end
    end

    // masked byte writes into the array
    always_ff @(posedge sys_clk)
    begin
        if (clk_en && wr_cap)
        begin
            for (int l = 0; l < DM_W; l++)
            begin
                if (!dm_s[l])
                    mem[mem_index(wb, wc, wbeat, interleaved)][l*8+:8] <= dq_s[l*8+:8]; // see RULE_19
            end
        end
    end

    // read data and strobe, preamble one clock ahead
    logic rd_step;
    assign rd_step = state == ST_READ && ck_edge && !last_beat && !due;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dq_out <= '0;
            dq_oe <= 1'b0;
            dqs_out <= 1'b0;
            dqs_oe <= 1'b0;
        end
        else if (clk_en)
        begin
            if (due_rd)
            begin
                dq_out <= mem[mem_index(sb[0], sc[0], 3'h0, interleaved)]; // see RULE_08
                dq_oe <= 1'b1;
                dqs_out <= 1'b1;
                dqs_oe <= 1'b1;
            end
            else if (rd_step)
            begin
                dq_out <= mem[mem_index(cur_bank, cur_col, beat + 3'h1, interleaved)];
                dqs_out <= ~dqs_out; // see RULE_08
            end
            else if (pre_next && state != ST_READ)
            begin
                dqs_oe <= 1'b1; // see RULE_08
                dqs_out <= 1'b0;
                dq_oe <= 1'b0;
            end
            else if (state == ST_READ && ck_edge && last_beat)
            begin
                dq_oe <= 1'b0;
                dqs_oe <= 1'b0;
                dqs_out <= 1'b0;
            end
        end
    end

    // bank open state, precharge and auto-precharge
    logic burst_end;
    assign burst_end = !due && ((state == ST_READ && ck_edge && last_beat) ||
                                (state == ST_WRITE && wr_cap && last_beat));
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            bank_open <= '0;
        else if (clk_en)
        begin
            if (cmd && op == OP_ACT)
                bank_open[ba_s] <= 1'b1;
            else if (is_pre && addr_s[AP_BIT])
                bank_open <= '0; // see RULE_20
            else if (is_pre)
                bank_open[ba_s] <= 1'b0; // see RULE_20
            if (burst_end && cur_ap)
                bank_open[cur_bank] <= 1'b0; // see RULE_24
        end
    end

    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_read_queued: assert property (clk_en && is_rd && accept |=> sv[rl - 4'h1]) // see RULE_07
        else $error("read not scheduled at read latency");
    a_write_queued: assert property (clk_en && is_wr && accept |=> sv[wl - 4'h1]) // see RULE_13
        else $error("write not scheduled at write latency");
    a_read_preamble: assert property (clk_en && pre_next && state == ST_IDLE
        |=> dqs_oe && !dqs_out && !dq_oe) // see RULE_08
        else $error("read preamble missing");
    a_first_beat: assert property (clk_en && due_rd |=> dqs_out && dq_oe && beat == 3'h0) // see RULE_08
        else $error("first read beat not on rising strobe");
    a_burst_length: assert property (state != ST_IDLE |-> beat <= last) // see RULE_01
        else $error("beat beyond burst length");
    a_write_ignore: assert property (state != ST_WRITE && !due_wr |-> !wr_cap) // see RULE_15
        else $error("write data taken outside burst");
    a_closed_reject: assert property (clk_en && (is_rd | is_wr) && !bank_open[ba_s]
        |=> cmd_reject ##1 !cmd_reject) // see RULE_25
        else $error("column command to closed bank not rejected");
    a_pre_all: assert property (clk_en && is_pre && addr_s[AP_BIT] && !(burst_end && cur_ap)
        |=> bank_open == '0) // see RULE_20
        else $error("precharge all left a bank open");
    a_seq_nibble: assert property (state == ST_READ && !interleaved && !burst_len8
        |-> mem_index(cur_bank, cur_col, beat, 1'b0) >> 2 ==
            mem_index(cur_bank, cur_col, 3'h0, 1'b0) >> 2) // see RULE_03
        else $error("sequential burst left its nibble");
    a_no_dq_write: assert property (state == ST_WRITE |-> !dq_oe) // see RULE_19
        else $error("data driven during write");

    c_read_burst: cover property (due_rd ##[1:200] state == ST_IDLE);
    c_write_burst: cover property (due_wr ##[1:200] burst_end);
    c_interrupt: cover property (state == ST_READ && beat == 3'h3 && due_rd);
    c_auto_pre: cover property (burst_end && cur_ap);
endmodule

//--- sim/ddr2_ctrl_model.sv
// controller-side model: link clock, command pins, write strobe, data and mask
`timescale 1ns/1ps
module ddr2_ctrl_model #(
    parameter int DQ_W = 16
) (
    output logic ck,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [1:0] ba,
    output logic [12:0] addr,
    output logic [DQ_W-1:0] dq_in,
    output logic dqs_in,
    output logic [DQ_W/8-1:0] dm_in
);
    realtime t_cmd;
    // free-running link clock, offset 1 ns from the system clock edges
    initial
    begin
        ck = 1'b0;
        cs_n = 1'b1;
        {ras_n, cas_n, we_n} = 3'h7;
        ba = 2'h0;
        addr = 13'h0;
        dq_in = '0;
        dqs_in = 1'b0;
        dm_in = '0;
        #1;
        forever #40 ck = ~ck;
    end
    // command set on a ck fall and held to the next fall; no terminate command exists
    task automatic issue(input logic [2:0] op, input logic [1:0] b, input logic [12:0] a);
        @(negedge ck);
        {ras_n, cas_n, we_n} = op;
        cs_n = 1'b0;
        ba = b;
        addr = a;
        @(posedge ck);
        t_cmd = $realtime;
        @(negedge ck);
        cs_n = 1'b1;
        {ras_n, cas_n, we_n} = ~op;
        ba = ~b;
        addr = ~a;
    endtask
    // strobe held low through the preamble clock, then data centred on each strobe edge
    task automatic wr_data(input int wl, input int n, input logic [DQ_W-1:0] d [16],
                           input logic [DQ_W/8-1:0] m [16]);
        repeat (wl - 1) @(negedge ck);
        for (int i = 0; i < n; i++)
        begin
            #20;
            dq_in = d[i];
            dm_in = m[i];
            #20;
            dqs_in = ~dqs_in;
        end
        #20;
        dq_in = ~dq_in;
        dm_in = ~dm_in;
    endtask
endmodule

//--- sim/ddr2_burst_access_timing_tb.sv
// self-checking bench for the ddr2 column-access burst engine
`timescale 1ns/1ps
module ddr2_burst_access_timing_tb;
    import ddr2_burst_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic ck, cs_n, ras_n, cas_n, we_n, dqs_in, dq_oe, dqs_out, dqs_oe;
    logic burst_len8, interleaved, cmd_reject;
    logic [1:0] ba, dm_in;
    logic [12:0] addr;
    logic [12:0] rnd;
    logic [15:0] dq_in, dq_out;
    logic [3:0] bank_open;
    logic [2:0] cas_lat, add_lat;
    logic [15:0] mem [4][8];
    logic [15:0] rq [$];
    logic [15:0] eq [$];
    logic prev_dqs = 1'b0;
    logic prev_oe = 1'b0;
    logic prev_soe = 1'b0;
    logic il = 1'b0;
    realtime t_first;
    int bl = 4, cl = 3, al = 0, seed = 32'hf079;
    int errors = 0, compares = 0, rejects = 0, oe_rises = 0;

    ddr2_burst_access_timing #(.DQ_W(16), .COL_W(3)) ddr2_burst_access_timing_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .ck(ck), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .dqs_in(dqs_in), .dqs_out(dqs_out), .dqs_oe(dqs_oe),
        .dm_in(dm_in), .bank_open(bank_open), .burst_len8(burst_len8),
        .interleaved(interleaved), .cas_lat(cas_lat), .add_lat(add_lat), .cmd_reject(cmd_reject));
    ddr2_ctrl_model #(.DQ_W(16)) ddr2_ctrl_model_i (
        .ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
        .addr(addr), .dq_in(dq_in), .dqs_in(dqs_in), .dm_in(dm_in));

    always #2 sys_clk = ~sys_clk;

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // expected column of a beat
    function automatic logic [2:0] col_of(input logic [2:0] s, input logic [2:0] b,
                                          input logic t);
        col_of = t ? (s ^ b) : {s[2] ^ b[2], s[1:0] + b[1:0]};
    endfunction
    // read beats taken on each strobe change while the device drives data
    always @(negedge sys_clk)
    begin
        if (cmd_reject === 1'b1)
            rejects++;
        if (dq_oe === 1'b1 && prev_oe !== 1'b1)
        begin
            t_first = $realtime;
            oe_rises++;
            check("read strobe start", 3'h5, {prev_soe, prev_dqs, dqs_out});
        end
        if (dq_oe === 1'b1 && (dqs_out !== prev_dqs || prev_oe !== 1'b1))
            rq.push_back(dq_out);
        prev_dqs = dqs_out;
        prev_oe = dq_oe;
        prev_soe = dqs_oe;
    end
    task automatic set_mode(input int b8, input int t, input int c, input int a);
        ddr2_ctrl_model_i.issue(OP_MRS, BA_MRS,
            13'((c << CL_LSB) | (t << BT_BIT) | (b8 ? BL8_CODE : BL4_CODE)));
        ddr2_ctrl_model_i.issue(OP_MRS, BA_EMRS, 13'(a << AL_LSB));
        bl = b8 ? 8 : 4;
        il = t[0];
        cl = c;
        al = a;
        check("burst_len8", b8, burst_len8);
        check("interleaved", t, interleaved);
        check("cas_lat", c, cas_lat);
        check("add_lat", a, add_lat);
    endtask
    // random data and masks; two surplus beats follow the burst
    task automatic do_write(input logic [1:0] b, input logic [2:0] s, input logic mk,
                            input int cut);
        logic [15:0] d [16];
        logic [1:0] m [16];
        logic [2:0] c;
        logic [1:0] bb;
        logic [2:0] ss;
        int j;
        for (int i = 0; i < 16; i++)
        begin
            d[i] = 16'($random(seed));
            m[i] = mk ? 2'($random(seed)) : 2'h0;
        end
        for (int i = 0; i < bl + cut; i++)
        begin
            bb = (cut > 0 && i >= cut) ? ~b : b;
            ss = (cut > 0 && i >= cut) ? ~s : s;
            j = (i >= cut) ? i - cut : i;
            c = col_of(ss, j[2:0], il);
            for (int k = 0; k < 2; k++)
                if (!m[i][k])
                    mem[bb][c][k*8 +: 8] = d[i][k*8 +: 8];
        end
        ddr2_ctrl_model_i.issue(OP_WR, b, {3'h0, 7'h0, s});
        // a cutting write lands two clocks after the first while data streams on
        fork
            ddr2_ctrl_model_i.wr_data(al + cl - 1, bl + cut + 2, d, m);
            if (cut > 0)
                ddr2_ctrl_model_i.issue(OP_WR, ~b, {3'h0, 7'h0, ~s});
        join
        repeat (cl + 4) @(negedge ck); // write to read spacing
    endtask
    task automatic expect_read(input logic [1:0] b, input logic [2:0] s, input int n);
        for (int i = 0; i < n; i++)
            eq.push_back(mem[b][col_of(s, i[2:0], il)]);
    endtask
    task automatic drain(input string what);
        repeat (al + cl + 8) @(negedge ck);
        check({what, " beat count"}, eq.size(), rq.size());
        for (int i = 0; i < eq.size() && i < rq.size(); i++)
            check(what, eq[i], rq[i]);
        eq.delete();
        rq.delete();
        $display("test %s done", what);
    endtask
    task automatic finish_test;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // watchdog well beyond the expected run length
    initial
    begin
        #300000;
        errors++;
        finish_test();
    end
    initial
    begin
        repeat (4) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        check("reset cas_lat", CL_RESET, cas_lat);
        check("reset add_lat", AL_RESET, add_lat);
        check("reset bank_open", 4'h0, bank_open);
        check("reset burst_len8", 1'b0, burst_len8);
        // read to a closed bank is refused
        ddr2_ctrl_model_i.issue(OP_RD, 2'h1, 13'h0);
        repeat (12) @(negedge ck);
        check("reject count", 1, rejects);
        check("reject data", 0, rq.size());
        for (int i = 0; i < 4; i++)
            ddr2_ctrl_model_i.issue(OP_ACT, i[1:0], 13'h0);
        check("all open", 4'hf, bank_open);
        // fill every column unmasked
        set_mode(1, 0, 3, 0);
        for (int i = 0; i < 4; i++)
            do_write(i[1:0], 3'h0, 1'b0, 0);
        // every burst length and order, random latencies and starts
        for (int n = 0; n < 12; n++)
        begin
            set_mode(n % 2, (n / 2) % 2, 3 + {$random(seed)} % 3, {$random(seed)} % 5);
            rnd = 13'($random(seed));
            do_write(rnd[1:0], rnd[4:2], 1'b1, 0); // drain spaces read to write
            rq.delete();
            ddr2_ctrl_model_i.issue(OP_RD, rnd[6:5], {3'h0, 7'h0, rnd[9:7]});
            expect_read(rnd[6:5], rnd[9:7], bl);
            drain("random read");
            check("read latency", al + cl,
                  int'((t_first - ddr2_ctrl_model_i.t_cmd) / 80.0));
        end
        // seamless four-beat reads to two banks
        set_mode(0, 0, 3, 0);
        oe_rises = 0;
        ddr2_ctrl_model_i.issue(OP_RD, 2'h0, 13'h1);
        ddr2_ctrl_model_i.issue(OP_RD, 2'h2, 13'h2); // two clocks later
        expect_read(2'h0, 3'h1, 4);
        expect_read(2'h2, 3'h2, 4);
        drain("seamless read");
        check("seamless single burst", 1, oe_rises);
        // eight-beat read cut by a read two clocks later
        set_mode(1, 1, 4, 1);
        ddr2_ctrl_model_i.issue(OP_RD, 2'h1, 13'h5);
        ddr2_ctrl_model_i.issue(OP_RD, 2'h3, 13'h3); // exactly two clocks later
        expect_read(2'h1, 3'h5, 4);
        expect_read(2'h3, 3'h3, 8);
        drain("interrupted read");
        // eight-beat write cut after four beats, then both banks read back
        do_write(2'h0, 3'h6, 1'b1, 4);
        ddr2_ctrl_model_i.issue(OP_RD, 2'h0, 13'h6);
        repeat (2) @(negedge ck);
        ddr2_ctrl_model_i.issue(OP_RD, 2'h3, 13'h1);
        expect_read(2'h0, 3'h6, 8);
        expect_read(2'h3, 3'h1, 8);
        drain("interrupted write");
        // auto-precharge read, then single and all-bank precharge
        set_mode(0, 0, 3, 0);
        ddr2_ctrl_model_i.issue(OP_RD, 2'h2, 13'h400);
        expect_read(2'h2, 3'h0, 4);
        drain("auto-precharge read");
        check("auto-precharge closes", 4'hb, bank_open);
        ddr2_ctrl_model_i.issue(OP_PRE, 2'h1, 13'h0); // past read spacing
        check("precharge one bank", 4'h9, bank_open);
        ddr2_ctrl_model_i.issue(OP_PRE, 2'h0, 13'h400); // no reactivation follows
        check("precharge all", 4'h0, bank_open);
        $display("test precharge done");
        finish_test();
    end
endmodule
